// ===== hw/fdma_pkg.sv
package fdma_pkg;
  localparam int NCH      = 4;
  localparam int NPIN     = 7;
  localparam int NPER_MAX = 24;
  localparam int ADDR_W   = 26;
  localparam int CNT_W    = 25;
  localparam int MODE_W   = 13;
  localparam int TSEL_W   = 5;

  // register map: channel c at 8'h20*c, global block at 8'h80
  localparam int GLB_BIT = 7;
  localparam int CH_LO   = 5;
  localparam int RI_LO   = 2;
  localparam logic [2:0] RI_SRC  = 3'h0;
  localparam logic [2:0] RI_DST  = 3'h1;
  localparam logic [2:0] RI_CNT  = 3'h2;
  localparam logic [2:0] RI_RLD  = 3'h3;
  localparam logic [2:0] RI_MODE = 3'h4;
  localparam logic [1:0] GI_STAT = 2'h0;
  localparam logic [1:0] GI_MASK = 2'h1;
  localparam logic [1:0] GI_SWT  = 2'h2;

  // channel_mode_register fields
  localparam int MS_LO    = 0;
  localparam int SZ_LO    = 2;
  localparam int SINC_BIT = 4;
  localparam int DINC_BIT = 5;
  localparam int BOTH_BIT = 6;
  localparam int TSEL_LO  = 8;
  localparam logic [1:0] MS_OFF    = 2'h0;
  localparam logic [1:0] MS_SINGLE = 2'h1;
  localparam logic [1:0] MS_REPEAT = 2'h3;
  localparam logic [1:0] SZ_8      = 2'h0;
  localparam logic [1:0] SZ_16     = 2'h1;
  localparam logic [1:0] SZ_32     = 2'h2;
  localparam logic [TSEL_W-1:0] SEL_PIN_LO = 5'h01;
  localparam logic [TSEL_W-1:0] SEL_PER_LO = 5'h08;

  // reset and fixed values
  localparam logic [CNT_W-1:0]  CNT_ONE   = 25'h0000001;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 25'h0000000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 26'h0000000;
  localparam logic [MODE_W-1:0] MODE_RST  = 13'h0000;
  localparam logic [NPIN-1:0]   PIN_IDLE  = 7'h7f;
  localparam logic [31:0]       WORD_ZERO = 32'h00000000;

  typedef enum logic [1:0] {FDMA_IDLE, FDMA_RD, FDMA_WR} fdma_phase_t;

  typedef struct packed {
    logic [NCH-1:0][ADDR_W-1:0] src;
    logic [NCH-1:0][ADDR_W-1:0] dst;
    logic [NCH-1:0][ADDR_W-1:0] src0;
    logic [NCH-1:0][ADDR_W-1:0] dst0;
    logic [NCH-1:0][CNT_W-1:0]  cnt;
    logic [NCH-1:0][CNT_W-1:0]  rld;
    logic [NCH-1:0][MODE_W-1:0] mode;
    logic [NCH-1:0]             pend;
    logic [NCH-1:0]             done;
    logic [NCH-1:0]             mask;
    fdma_phase_t                phase;
    logic [1:0]                 ch;
    logic [31:0]                data;
    logic [31:0]                m_addr;
    logic                       m_rd;
    logic                       m_wr;
    logic [31:0]                m_wdata;
    logic [3:0]                 m_be;
    logic                       s_wait;
    logic [31:0]                s_rdata;
    logic                       irq;
  } fdma_state_t;

  typedef struct packed {
    logic [NPIN-1:0]     pin_q;
    logic [NPER_MAX-1:0] per_q;
  } fdma_trig_state_t;

  function automatic logic [3:0] be_of(input logic [1:0] sz, input logic [1:0] lo);
    case (sz)
      SZ_8:    be_of = 4'h1 << lo;
      SZ_16:   be_of = 4'h3 << lo;
      default: be_of = 4'hf;
    endcase
  endfunction : be_of

  function automatic logic [ADDR_W-1:0] step_of(input logic [1:0] sz);
    case (sz)
      SZ_8:    step_of = 26'h0000001;
      SZ_16:   step_of = 26'h0000002;
      default: step_of = 26'h0000004;
    endcase
  endfunction : step_of

  // 26-bit window onto the low and high 32 Mbyte of the map
  function automatic logic [31:0] ext_addr(input logic [ADDR_W-1:0] a);
    ext_addr = {{(32 - ADDR_W){a[ADDR_W-1]}}, a};
  endfunction : ext_addr
endpackage : fdma_pkg

// ===== hw/fdma_req_if.sv
`timescale 1ns/1ps
interface fdma_req_if;
  logic [fdma_pkg::NCH-1:0] req;
  logic [1:0]               idx;
  logic                     any;
  modport arb (input req, output idx, output any);
  modport eng (output req, input idx, input any);
endinterface : fdma_req_if

// ===== hw/fdma_arb.sv
`timescale 1ns/1ps
module fdma_arb (
  // request lines
  fdma_req_if.arb rq
);
  always_comb begin
    rq.idx = 2'h0;
    rq.any = |rq.req;
    for (int c = fdma_pkg::NCH - 1; c >= 0; c--) begin
      if (rq.req[c]) begin
        rq.idx = 2'(c);
      end
    end
  end
endmodule : fdma_arb

// ===== hw/fdma_trig.sv
`timescale 1ns/1ps
module fdma_trig #(
  parameter int NPER = 24
) (
  // clock and reset
  input  wire logic                              clk_sys,
  input  wire logic                              rst_n,
  // raw sources
  input  wire logic [fdma_pkg::NPIN-1:0]         pin,
  input  wire logic [NPER-1:0]                   per,
  // edge pulses
  output logic      [fdma_pkg::NPIN-1:0]         pin_fall,
  output logic      [fdma_pkg::NPIN-1:0]         pin_any,
  output logic      [fdma_pkg::NPER_MAX-1:0]     per_rise
);
  fdma_pkg::fdma_trig_state_t r, n;
  logic [fdma_pkg::NPER_MAX-1:0] per_w;

  always_comb begin
    per_w    = fdma_pkg::NPER_MAX'(per);
    n.pin_q  = pin;
    n.per_q  = per_w;
    pin_fall = r.pin_q & ~pin;
    pin_any  = r.pin_q ^ pin;
    per_rise = per_w & ~r.per_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r.pin_q <= fdma_pkg::PIN_IDLE;
      r.per_q <= '0;
    end else begin
      r <= n;
    end
  end

  fall_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pin_fall[0] |-> (!pin[0] && r.pin_q[0] && pin_any[0]))
    else $error("falling edge pulse without a falling edge");
endmodule : fdma_trig

// ===== hw/fdma_top.sv
// The implementer's own choices: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module fdma_top #(
  parameter int NPER = 24
) (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst_n,
  // register slave
  input  wire logic [7:0]                    avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  // transfer master
  output logic      [31:0]                   avm_address,
  output logic                               avm_read,
  output logic                               avm_write,
  output logic      [31:0]                   avm_writedata,
  output logic      [3:0]                    avm_byteenable,
  input  wire logic [31:0]                   avm_readdata,
  input  wire logic                          avm_waitrequest,
  // trigger sources
  input  wire logic [fdma_pkg::NPIN-1:0]     external_irq_pin,
  input  wire logic [NPER-1:0]               periph_irq,
  // interrupt
  output logic                               irq
);
  if (NPER < 1 || NPER > fdma_pkg::NPER_MAX) begin : g_bad_nper
    $error("NPER out of range");
  end

  fdma_pkg::fdma_state_t r, n;
  fdma_req_if rq ();
  logic [fdma_pkg::NPIN-1:0]     pin_fall;
  logic [fdma_pkg::NPIN-1:0]     pin_any;
  logic [fdma_pkg::NPER_MAX-1:0] per_rise;
  logic                          acc;
  logic                          wr;
  logic                          xfer_done;
  logic [31:0]                   wv;
  logic [31:0]                   cur;
  logic [fdma_pkg::NCH-1:0]      swt;
  logic [fdma_pkg::TSEL_W-1:0]   sel;
  logic [1:0]                    c;
  logic [1:0]                    cw;
  logic [2:0]                    ri;

  fdma_trig #(.NPER(NPER)) u_trig (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .pin      (external_irq_pin),
    .per      (periph_irq),
    .pin_fall (pin_fall),
    .pin_any  (pin_any),
    .per_rise (per_rise)
  );

  fdma_arb u_arb (
    .rq (rq)
  );

  function automatic logic mode_on(input logic [fdma_pkg::MODE_W-1:0] m);
    mode_on = (m[fdma_pkg::MS_LO +: 2] == fdma_pkg::MS_SINGLE) ||
              (m[fdma_pkg::MS_LO +: 2] == fdma_pkg::MS_REPEAT);
  endfunction : mode_on

  function automatic logic [31:0] rd_word(input fdma_pkg::fdma_state_t s,
                                          input logic [7:0] a);
    logic [1:0] k;
    k = a[fdma_pkg::CH_LO +: 2];
    rd_word = fdma_pkg::WORD_ZERO;
    if (!a[fdma_pkg::GLB_BIT]) begin
      case (a[fdma_pkg::RI_LO +: 3])
        fdma_pkg::RI_SRC:  rd_word = 32'(s.src[k]);
        fdma_pkg::RI_DST:  rd_word = 32'(s.dst[k]);
        fdma_pkg::RI_CNT:  rd_word = 32'(s.cnt[k]);
        fdma_pkg::RI_RLD:  rd_word = 32'(s.rld[k]);
        fdma_pkg::RI_MODE: rd_word = 32'(s.mode[k]);
        default:           rd_word = fdma_pkg::WORD_ZERO;
      endcase
    end else if (a[6:4] == 3'h0) begin
      case (a[fdma_pkg::RI_LO +: 2])
        fdma_pkg::GI_STAT: rd_word = 32'(s.done);
        fdma_pkg::GI_MASK: rd_word = 32'(s.mask);
        default:           rd_word = fdma_pkg::WORD_ZERO;
      endcase
    end
  endfunction : rd_word

  always_comb begin
    n         = r;
    rq.req    = '0;
    xfer_done = 1'b0;
    swt       = '0;
    sel       = '0;
    c         = r.ch;
    cw        = avs_address[fdma_pkg::CH_LO +: 2];
    ri        = avs_address[fdma_pkg::RI_LO +: 3];
    // one wait cycle, then data and write take effect on the low-wait edge
    acc       = (avs_read || avs_write) && !r.s_wait;
    wr        = avs_write && acc;
    n.s_wait  = 1'b1;
    if ((avs_read || avs_write) && r.s_wait) begin
      n.s_wait  = 1'b0;
      n.s_rdata = rd_word(r, avs_address);
    end
    cur = rd_word(r, avs_address);
    for (int b = 0; b < 4; b++) begin
      wv[b*8 +: 8] = avs_byteenable[b] ? avs_writedata[b*8 +: 8] : cur[b*8 +: 8];
    end

    if (wr && !avs_address[fdma_pkg::GLB_BIT]) begin
      case (ri)
        fdma_pkg::RI_SRC: begin
          n.src[cw]  = wv[fdma_pkg::ADDR_W-1:0];
          n.src0[cw] = wv[fdma_pkg::ADDR_W-1:0];
        end
        fdma_pkg::RI_DST: begin
          n.dst[cw]  = wv[fdma_pkg::ADDR_W-1:0];
          n.dst0[cw] = wv[fdma_pkg::ADDR_W-1:0];
        end
        fdma_pkg::RI_CNT:  n.cnt[cw]  = wv[fdma_pkg::CNT_W-1:0];
        fdma_pkg::RI_RLD:  n.rld[cw]  = wv[fdma_pkg::CNT_W-1:0];
        fdma_pkg::RI_MODE: n.mode[cw] = wv[fdma_pkg::MODE_W-1:0];
        default: ;
      endcase
    end else if (wr && avs_address[6:4] == 3'h0) begin
      case (avs_address[fdma_pkg::RI_LO +: 2])
        fdma_pkg::GI_STAT: n.done = r.done & ~(avs_writedata[fdma_pkg::NCH-1:0]
                                               & {fdma_pkg::NCH{avs_byteenable[0]}});
        fdma_pkg::GI_MASK: n.mask = wv[fdma_pkg::NCH-1:0];
        fdma_pkg::GI_SWT:  swt    = avs_writedata[fdma_pkg::NCH-1:0]
                                    & {fdma_pkg::NCH{avs_byteenable[0]}};
        default: ;
      endcase
    end

    // disabled or exhausted channels take no grant
    for (int k = 0; k < fdma_pkg::NCH; k++) begin
      rq.req[k] = r.pend[k] && mode_on(r.mode[k]) && (r.cnt[k] != fdma_pkg::CNT_ZERO);
    end

    case (r.phase)
      fdma_pkg::FDMA_IDLE: begin
        if (rq.any) begin
          c          = rq.idx;
          n.ch       = c;
          n.pend[c]  = 1'b0;
          n.phase    = fdma_pkg::FDMA_RD;
          n.m_rd     = 1'b1;
          n.m_addr   = fdma_pkg::ext_addr(r.src[c]);
          n.m_be     = fdma_pkg::be_of(r.mode[c][fdma_pkg::SZ_LO +: 2], r.src[c][1:0]);
        end
      end
      fdma_pkg::FDMA_RD: begin
        if (!avm_waitrequest) begin
          n.data    = avm_readdata >> {r.src[c][1:0], 3'h0};
          n.m_rd    = 1'b0;
          n.m_wr    = 1'b1;
          n.m_addr  = fdma_pkg::ext_addr(r.dst[c]);
          n.m_wdata = (avm_readdata >> {r.src[c][1:0], 3'h0}) << {r.dst[c][1:0], 3'h0};
          n.m_be    = fdma_pkg::be_of(r.mode[c][fdma_pkg::SZ_LO +: 2], r.dst[c][1:0]);
          n.phase   = fdma_pkg::FDMA_WR;
        end
      end
      fdma_pkg::FDMA_WR: begin
        if (!avm_waitrequest) begin
          xfer_done = 1'b1;
          n.m_wr    = 1'b0;
          n.phase   = fdma_pkg::FDMA_IDLE;
          // engine update wins over a register write in the same cycle
          if (r.mode[c][fdma_pkg::SINC_BIT]) begin
            n.src[c] = r.src[c] + fdma_pkg::step_of(r.mode[c][fdma_pkg::SZ_LO +: 2]);
          end else begin
            n.src[c] = r.src[c];
          end
          if (r.mode[c][fdma_pkg::DINC_BIT]) begin
            n.dst[c] = r.dst[c] + fdma_pkg::step_of(r.mode[c][fdma_pkg::SZ_LO +: 2]);
          end else begin
            n.dst[c] = r.dst[c];
          end
          n.cnt[c] = r.cnt[c] - fdma_pkg::CNT_ONE;
          if (r.cnt[c] == fdma_pkg::CNT_ONE) begin
            n.done[c] = 1'b1;
            if (r.mode[c][fdma_pkg::MS_LO +: 2] == fdma_pkg::MS_REPEAT) begin
              n.cnt[c] = r.rld[c];
              n.src[c] = r.src0[c];
              n.dst[c] = r.dst0[c];
            end
          end
        end
      end
      default: n.phase = fdma_pkg::FDMA_IDLE;
    endcase

    // a trigger in the grant cycle is kept, not lost
    for (int k = 0; k < fdma_pkg::NCH; k++) begin
      sel = r.mode[k][fdma_pkg::TSEL_LO +: fdma_pkg::TSEL_W];
      if (swt[k]) begin
        n.pend[k] = mode_on(n.mode[k]);
      end else if (sel >= fdma_pkg::SEL_PER_LO) begin
        if (per_rise[5'(sel - fdma_pkg::SEL_PER_LO)] && mode_on(n.mode[k])) begin
          n.pend[k] = 1'b1;
        end
      end else if (sel >= fdma_pkg::SEL_PIN_LO) begin
        if ((r.mode[k][fdma_pkg::BOTH_BIT] ? pin_any[3'(sel - fdma_pkg::SEL_PIN_LO)]
                                           : pin_fall[3'(sel - fdma_pkg::SEL_PIN_LO)])
            && mode_on(n.mode[k])) begin
          n.pend[k] = 1'b1;
        end
      end
      // a finished run drops late triggers so a reprogrammed channel starts clean
      if (!mode_on(n.mode[k]) || n.cnt[k] == fdma_pkg::CNT_ZERO) begin
        n.pend[k] = 1'b0;
      end
    end
    n.irq = |(n.done & n.mask);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r.src     <= {fdma_pkg::NCH{fdma_pkg::ADDR_RST}};
      r.dst     <= {fdma_pkg::NCH{fdma_pkg::ADDR_RST}};
      r.src0    <= {fdma_pkg::NCH{fdma_pkg::ADDR_RST}};
      r.dst0    <= {fdma_pkg::NCH{fdma_pkg::ADDR_RST}};
      r.cnt     <= {fdma_pkg::NCH{fdma_pkg::CNT_ZERO}};
      r.rld     <= {fdma_pkg::NCH{fdma_pkg::CNT_ZERO}};
      r.mode    <= {fdma_pkg::NCH{fdma_pkg::MODE_RST}};
      r.pend    <= '0;
      r.done    <= '0;
      r.mask    <= '0;
      r.phase   <= fdma_pkg::FDMA_IDLE;
      r.ch      <= 2'h0;
      r.data    <= fdma_pkg::WORD_ZERO;
      r.m_addr  <= fdma_pkg::WORD_ZERO;
      r.m_rd    <= 1'b0;
      r.m_wr    <= 1'b0;
      r.m_wdata <= fdma_pkg::WORD_ZERO;
      r.m_be    <= 4'h0;
      r.s_wait  <= 1'b1;
      r.s_rdata <= fdma_pkg::WORD_ZERO;
      r.irq     <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign avs_readdata    = r.s_rdata;
  assign avs_waitrequest = r.s_wait;
  assign avm_address     = r.m_addr;
  assign avm_read        = r.m_rd;
  assign avm_write       = r.m_wr;
  assign avm_writedata   = r.m_wdata;
  assign avm_byteenable  = r.m_be;
  assign irq             = r.irq;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  prio_low_a: assert property (rq.req[0] |-> (rq.idx == 2'h0 && rq.any))
    else $error("channel 0 request not granted first");

  prio_grant_a: assert property ((r.phase == fdma_pkg::FDMA_IDLE) && rq.req[0]
    |=> (r.phase == fdma_pkg::FDMA_RD) && (r.ch == 2'h0))
    else $error("channel 0 lost arbitration");

  byte_lane_a: assert property (r.m_wr && r.mode[r.ch][fdma_pkg::SZ_LO +: 2] == fdma_pkg::SZ_8
    |-> $onehot(r.m_be))
    else $error("byte unit drives more than one lane");

  fixed_addr_a: assert property (xfer_done && !r.mode[r.ch][fdma_pkg::DINC_BIT] && !wr
    && r.cnt[r.ch] != fdma_pkg::CNT_ONE |=> r.dst[r.ch] == $past(r.dst[r.ch]))
    else $error("fixed destination moved");

  addr_step_a: assert property (xfer_done && r.mode[r.ch][fdma_pkg::SINC_BIT] && !wr
    && r.cnt[r.ch] != fdma_pkg::CNT_ONE
    |=> r.src[r.ch] == $past(r.src[r.ch]) + fdma_pkg::step_of($past(r.mode[r.ch][3:2])))
    else $error("source did not step by unit size");

  count_dec_a: assert property (xfer_done && r.cnt[r.ch] != fdma_pkg::CNT_ONE && !wr
    |=> r.cnt[r.ch] == $past(r.cnt[r.ch]) - fdma_pkg::CNT_ONE)
    else $error("counter did not decrement");

  single_stop_a: assert property (xfer_done && r.cnt[r.ch] == fdma_pkg::CNT_ONE
    && r.mode[r.ch][1:0] == fdma_pkg::MS_SINGLE && !wr
    |=> (r.cnt[r.ch] == fdma_pkg::CNT_ZERO) ##1 !(r.m_rd && r.ch == $past(r.ch, 2)))
    else $error("single run went on past zero");

  reload_a: assert property (xfer_done && r.cnt[r.ch] == fdma_pkg::CNT_ONE
    && r.mode[r.ch][1:0] == fdma_pkg::MS_REPEAT && !wr
    |=> r.cnt[r.ch] == $past(r.rld[r.ch]) && r.src[r.ch] == $past(r.src0[r.ch]))
    else $error("repeat reload missing");

  done_irq_a: assert property (xfer_done && r.cnt[r.ch] == fdma_pkg::CNT_ONE
    && r.mask[r.ch] && !wr |=> r.done[r.ch] && irq)
    else $error("run end raised no interrupt");

  off_idle_a: assert property ((r.phase == fdma_pkg::FDMA_IDLE)
    && r.mode[0][1:0] == fdma_pkg::MS_OFF |=> !(r.m_rd && r.ch == 2'h0))
    else $error("disabled channel started a transfer");

  addr_space_a: assert property ((r.m_rd || r.m_wr) |->
    (r.m_addr[31:25] == 7'h00) || (r.m_addr[31:25] == 7'h7f))
    else $error("address outside the two 32 Mbyte ranges");
endmodule : fdma_top

// ===== verif/fdma_mem_model.sv
`timescale 1ns/1ps
module fdma_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // transfer slave
  input  wire logic [31:0] address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // pacing
  input  wire logic        slow
);
  logic [31:0] mem [0:255];
  logic [1:0]  dly_reg;

  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
      dly_reg     <= 2'h0;
    end else if (!waitrequest) begin
      // answer lasts one cycle, then the data lines stop showing the word
      waitrequest <= 1'b1;
      readdata    <= ~readdata;
      dly_reg     <= 2'h0;
      for (int b = 0; b < 4; b++) begin
        if (write && byteenable[b]) begin
          mem[address[9:2]][8*b +: 8] <= writedata[8*b +: 8];
        end
      end
    end else if ((read || write) && (!slow || dly_reg == 2'h3)) begin
      waitrequest <= 1'b0;
      readdata    <= mem[address[9:2]];
    end else begin
      readdata <= ~readdata;
      dly_reg  <= (read || write) ? dly_reg + 2'h1 : 2'h0;
    end
  end
endmodule : fdma_mem_model

// ===== verif/fdma_top_tb.sv
`timescale 1ns/1ps
module fdma_top_tb;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] avm_address;
  logic [31:0] avm_writedata;
  logic [31:0] avm_readdata;
  logic        avm_read;
  logic        avm_write;
  logic        avm_waitrequest;
  logic [3:0]  avm_byteenable;
  logic [6:0]  ext_pin = 7'h7f;
  logic [23:0] per_irq = 24'h000000;
  logic        irq;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic [31:0] last_wr = 32'h00000000;
  logic [31:0] last_rd = 32'h00000000;
  int          bad_count = 0;
  int          check_count = 0;
  int          wr_beats = 0;

  always #2.5 clk_sys = ~clk_sys;

  fdma_top #(.NPER(24)) i_fdma_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avm_address(avm_address), .avm_read(avm_read), .avm_write(avm_write),
    .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
    .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
    .external_irq_pin(ext_pin), .periph_irq(per_irq), .irq(irq));

  fdma_mem_model i_fdma_mem_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .address(avm_address), .read(avm_read),
    .write(avm_write), .writedata(avm_writedata), .byteenable(avm_byteenable),
    .readdata(avm_readdata), .waitrequest(avm_waitrequest), .slow(slow));

  always @(posedge clk_sys) begin
    if (avm_write && !avm_waitrequest) begin
      wr_beats <= wr_beats + 1;
      last_wr  <= avm_address;
    end
    if (avm_read && !avm_waitrequest) begin
      last_rd <= avm_address;
    end
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    if (n >= 50) chk(32'h1, 32'h0, "register bus hang");
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 32'h00000000);
    chk(rd, e, m);
  endtask : rchk

  task automatic wait_beats(input int n);
    int t;
    int k;
    t = wr_beats + n;
    k = 0;
    while (wr_beats < t && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 300) chk(32'h1, 32'h0, "transfer hang");
    repeat (3) @(posedge clk_sys);
  endtask : wait_beats

  task automatic prog(input logic [1:0] c, input logic [31:0] s, input logic [31:0] d,
                      input logic [31:0] n, input logic [31:0] m);
    bus(1'b1, {c, 5'h00}, s);
    bus(1'b1, {c, 5'h04}, d);
    bus(1'b1, {c, 5'h08}, n);
    bus(1'b1, {c, 5'h0c}, n);
    bus(1'b1, {c, 5'h10}, m);
  endtask : prog

  function automatic logic [31:0] md(input logic [1:0] ms, input logic [1:0] sz,
                                     input logic si, input logic di, input logic [4:0] sel);
    md = {19'h00000, sel, 2'h0, di, si, sz, ms};
  endfunction : md

  initial begin
    i_fdma_mem_model.mem[8'h40] = 32'h44332211;
    i_fdma_mem_model.mem[8'h41] = 32'h88776655;
    for (int i = 8'h80; i < 8'hff; i++) i_fdma_mem_model.mem[i] = 32'h00000000;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk(8'h10, 32'h00000000, "mode reset");
    rchk(8'h90, 32'h00000000, "unmapped read");
    $display("test reset done");
    bus(1'b1, 8'h84, 32'h0000000f);
    prog(2'h0, 32'h100, 32'h200, 32'h2, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_32, 1, 1, 5'h0));
    bus(1'b1, 8'h88, 32'h1);
    wait_beats(1);
    chk({31'h0, irq}, 32'h0, "irq before end");
    bus(1'b1, 8'h88, 32'h1);
    wait_beats(1);
    chk(i_fdma_mem_model.mem[8'h81], 32'h88776655, "second word");
    rchk(8'h04, 32'h208, "dst stepped");
    rchk(8'h08, 32'h0, "count zero");
    chk({31'h0, irq}, 32'h1, "irq at end");
    bus(1'b1, 8'h88, 32'h1);
    repeat (20) @(posedge clk_sys);
    chk(i_fdma_mem_model.mem[8'h82], 32'h0, "no unit after end");
    bus(1'b1, 8'h80, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test single done");
    prog(2'h1, 32'h100, 32'h300, 32'h2, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_32, 1, 0, 5'h0));
    prog(2'h0, 32'h100, 32'h280, 32'h2, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_32, 1, 1, 5'h0));
    bus(1'b1, 8'h88, 32'h3);
    wait_beats(1);
    chk(last_wr, 32'h280, "channel 0 first");
    wait_beats(1);
    chk(last_wr, 32'h300, "channel 1 second");
    bus(1'b1, 8'h88, 32'h3);
    wait_beats(2);
    chk(last_wr, 32'h300, "channel 1 last");
    rchk(8'h24, 32'h300, "fixed dst");
    bus(1'b1, 8'h80, 32'hf);
    $display("test priority done");
    slow <= 1'b1;
    prog(2'h2, 32'h2000100, 32'h400, 32'h2,
         md(fdma_pkg::MS_REPEAT, fdma_pkg::SZ_16, 0, 1, 5'h0));
    bus(1'b1, 8'h88, 32'h4);
    wait_beats(1);
    bus(1'b1, 8'h88, 32'h4);
    wait_beats(1);
    chk(last_rd, 32'hfe000100, "high range");
    chk(i_fdma_mem_model.mem[8'h00], 32'h22112211, "fixed source halves");
    chk({16'h0000, i_fdma_mem_model.mem[8'h00][15:0]}, 32'h2211, "low half");
    rchk(8'h48, 32'h2, "count reloaded");
    rchk(8'h44, 32'h400, "dst reloaded");
    rchk(8'h80, 32'h4, "repeat done");
    bus(1'b1, 8'h50, 32'h0);
    bus(1'b1, 8'h88, 32'h4);
    repeat (20) @(posedge clk_sys);
    rchk(8'h48, 32'h2, "disabled");
    slow <= 1'b0;
    $display("test repeat done");
    bus(1'b1, 8'h84, 32'h0);
    prog(2'h3, 32'h101, 32'h503, 32'h2, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_8, 1, 1, 5'h1));
    @(posedge clk_sys);
    ext_pin[0] <= 1'b0;
    wait_beats(1);
    chk({24'h000000, i_fdma_mem_model.mem[8'h40][31:24]}, 32'h22, "pin byte");
    bus(1'b1, 8'h70, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_8, 1, 1, 5'h08));
    @(posedge clk_sys);
    per_irq[0] <= 1'b1;
    wait_beats(1);
    chk(last_wr, 32'h504, "periph trigger");
    chk({31'h0, irq}, 32'h0, "masked irq");
    rchk(8'h80, 32'hc, "masked done");
    bus(1'b1, 8'h68, 32'h2);
    bus(1'b1, 8'h70, md(fdma_pkg::MS_SINGLE, fdma_pkg::SZ_8, 1, 1, 5'h01) | 32'h40);
    ext_pin[0] <= 1'b1;
    wait_beats(1);
    chk(last_wr, 32'h505, "rising edge in both-edge mode");
    $display("test triggers done");
    give_verdict();
  end

  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end
endmodule : fdma_top_tb
